// file: hdl/port_pin_ctl.sv
// port pin control top: four 8-bit ports, led sink, shared reset pin
// assumes pins arrive synchronous to sys_clk; pads resolve o/oe
//
// Functional notes
// - index 02H selects the alternate-function-enable subregister through control
// - enable bit 0 gives plain gpio, direction from the direction bit
// - enable bit 1 hands pin control to the selected alternate function
// - two select-set bits choose one of four alternate functions
// - enable resets 00H ports A-C, 01H port D, 04H port A small
// - index 03H selects the output-control subregister through control
// - output-control bit 1 makes the pin open-drain, low only
// - open-drain acts on the driver, so alternate functions obey it
// - larger package: port D bit zero starts as shared reset
// - reset role: reset input and open-drain reset output
// - port D bit zero as gpio is output-only open-drain
// - port D bit zero has no pull-up, high drive or recovery
// - small package: reset shares port A bit two, full gpio later
// - system reset returns port A bit two to reset; no external low
// - port A bits zero and six carry timer input and output alike
// - port C offers per-pin led sink drive, four levels 3-20 mA
// - sink-enable register switches drivers, level pair sets current
// - at most 25 pins over ports A-D, each independent
// - sink-enable bit 1 sinks the port C pin, 0 tristates it; here 0 leaves the pin to its gpio or alternate function
// - level high/low pair: 00 3mA, 01 7mA, 10 13mA, 11 20mA
`timescale 1ns/10ps
module port_pin_ctl import port_ctl_pkg::*; #(
  parameter bit SMALL_PKG = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // register strobes
  input wire logic [11:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  // pins, index port*8+bit
  input wire logic [NPINS-1:0] pin_i,
  output logic [NPINS-1:0] pin_o,
  output logic [NPINS-1:0] pin_oe,
  // alternate functions
  input wire logic [NPINS-1:0][NALT-1:0] alt_o,
  input wire logic [NPINS-1:0][NALT-1:0] alt_oe,
  output logic [NPINS-1:0] periph_in,
  // shared reset pin
  input wire logic rst_drive_req,
  output logic ext_reset_req,
  // led sink controls to the analog drivers
  output logic [PORT_W-1:0] led_sink_on,
  output logic [PORT_W-1:0][1:0] led_level
);

  // ==========================================================
  // reset release
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ==========================================================
  // address decode
  localparam int RPIN = SMALL_PKG ? RST_PIN_SMALL : RST_PIN_LARGE;
  localparam logic [31:0] PRESENT = SMALL_PKG ? PRESENT_SMALL : PRESENT_LARGE;

  logic port_hit;
  logic [1:0] port_sel;
  logic [1:0] ofs;
  logic [7:0] idx_reg [NUM_PORTS];
  logic [7:0] bank_rd [NUM_PORTS];
  port_cfg_t cfg [NUM_PORTS];
  logic [7:0] led_en_reg;
  logic [7:0] lvlh_reg;
  logic [7:0] lvll_reg;
  logic [7:0] rdata_next;
  logic [NPINS-1:0] in_val;

  assign port_hit = cpu_addr[11:4] == PORT_BASE_ADDR[11:4];
  assign port_sel = cpu_addr[3:2];
  assign ofs = cpu_addr[1:0];

  // ==========================================================
  // index registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        idx_reg[p] <= IDX_RST;
      end
    end else if (cpu_wr && port_hit && ofs == OFS_INDEX) begin
      idx_reg[port_sel] <= cpu_wdata;
    end
  end

  // ==========================================================
  // per-port subregister banks
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_bank
    localparam logic [7:0] AFR = (p == PORT_D) ? AF_RST_D :
      ((p == PORT_A && SMALL_PKG) ? AF_RST_A_SMALL : AF_RST_ABC);

    port_subreg_bank #(
      .AF_RST(AFR)
    ) u_bank (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ctl_wr(cpu_wr && port_hit && ofs == OFS_CTRL && port_sel == 2'(p)),
      .out_wr(cpu_wr && port_hit && ofs == OFS_OUTPUT && port_sel == 2'(p)),
      .idx(idx_reg[p]),
      .wdata(cpu_wdata),
      .rd_data(bank_rd[p]),
      .cfg(cfg[p])
    );
  end

  // ==========================================================
  // led sink registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      led_en_reg <= LED_RST;
      lvlh_reg <= LED_RST;
      lvll_reg <= LED_RST;
    end else if (cpu_wr) begin
      if (cpu_addr == LED_EN_ADDR) begin
        led_en_reg <= cpu_wdata;
      end
      if (cpu_addr == LED_LVLH_ADDR) begin
        lvlh_reg <= cpu_wdata;
      end
      if (cpu_addr == LED_LVLL_ADDR) begin
        lvll_reg <= cpu_wdata;
      end
    end
  end

  // absent port C pins on the smaller packages never sink
  for (genvar b = 0; b < PORT_W; b++) begin : g_led
    assign led_sink_on[b] = led_en_reg[b] && PRESENT[PORT_C * PORT_W + b];
    assign led_level[b] = {lvlh_reg[b], lvll_reg[b]};
  end

  // ==========================================================
  // read data, one cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (port_hit) begin
      unique case (ofs)
        OFS_INDEX: rdata_next = idx_reg[port_sel];
        OFS_CTRL: rdata_next = bank_rd[port_sel];
        OFS_INPUT: rdata_next = in_val[port_sel * PORT_W +: PORT_W];
        OFS_OUTPUT: rdata_next = cfg[port_sel].out;
      endcase
    end else if (cpu_addr == LED_EN_ADDR) begin
      rdata_next = led_en_reg;
    end else if (cpu_addr == LED_LVLH_ADDR) begin
      rdata_next = lvlh_reg;
    end else if (cpu_addr == LED_LVLL_ADDR) begin
      rdata_next = lvll_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= RDATA_RST;
    end else if (cpu_rd) begin
      cpu_rdata <= rdata_next;
    end
  end

  // ==========================================================
  // pin cells
  logic rst_role;
  pin_cfg_t pcfg [NPINS];

  // reset role lives on the reset pin's enable bit with select zero
  assign rst_role = pcfg[RPIN].af && pcfg[RPIN].sel == RST_ROLE_SEL;

  for (genvar n = 0; n < NPINS; n++) begin : g_pin
    localparam int P = n / PORT_W;
    localparam int B = n % PORT_W;
    localparam bit IS_RST = (n == RPIN);
    localparam bit IS_PORTC = (P == PORT_C);

    assign pcfg[n] = '{dir: cfg[P].dir[B], af: cfg[P].af[B],
      sel: {cfg[P].sel2[B], cfg[P].sel1[B]}, oc: cfg[P].oc[B], out: cfg[P].out[B]};

    pin_drive_cell u_cell (
      .cfg(pcfg[n]),
      .present(PRESENT[n]),
      .out_only(IS_RST && !SMALL_PKG && !rst_role),
      .led_on(IS_PORTC && led_sink_on[B]),
      .rst_role(IS_RST && rst_role),
      .rst_drive(!rst_n || rst_drive_req),
      .alt_o(alt_o[n]),
      .alt_oe(alt_oe[n]),
      .pin_i(pin_i[n]),
      .pin_o(pin_o[n]),
      .pin_oe(pin_oe[n]),
      .in_val(in_val[n])
    );
  end

  // timer pins hand their level to both timer input and capture paths
  assign periph_in = in_val;

  // ==========================================================
  // reset request from the shared pin
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_reset_req <= 1'b0;
    end else begin
      ext_reset_req <= rst_role && !pin_i[RPIN];
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  logic ctl_wr_any;
  assign ctl_wr_any = cpu_wr && port_hit && ofs == OFS_CTRL;

  af_write_a: assert property (
    ctl_wr_any && idx_reg[port_sel] == IDX_AF
    |=> cfg[$past(port_sel)].af == $past(cpu_wdata))
    else $error("alternate enable write lost");

  oc_readback_a: assert property (
    ctl_wr_any && idx_reg[port_sel] == IDX_OC
    |=> bank_rd[$past(port_sel)] == $past(cpu_wdata))
    else $error("output control readback wrong");

  af_reset_value_a: assert property (
    $rose(rst_n) |-> cfg[PORT_D].af == AF_RST_D &&
      cfg[PORT_A].af == (SMALL_PKG ? AF_RST_A_SMALL : AF_RST_ABC))
    else $error("alternate enable reset value wrong");

  oc_reset_value_a: assert property (
    $rose(rst_n) |-> cfg[PORT_A].oc == OC_RST && cfg[PORT_C].oc == OC_RST)
    else $error("output control reset value wrong");

  od_no_high_a: assert property (
    (pin_oe & pin_o & {cfg[3].oc, cfg[2].oc, cfg[1].oc, cfg[0].oc}) == '0)
    else $error("open-drain pin driven high");

  gpio_drive_a: assert property (
    !pcfg[1].af && !pcfg[1].dir && !pcfg[1].oc ##1 $stable(cfg[0])
    |-> pin_oe[1] && pin_o[1] == pcfg[1].out)
    else $error("gpio output not driven");

  alt_take_a: assert property (
    pcfg[1].af && !pcfg[1].oc |-> pin_oe[1] == alt_oe[1][pcfg[1].sel])
    else $error("alternate function not in control");

  led_sink_a: assert property (
    led_sink_on[3] && !rst_role |-> pin_oe[PORT_C * PORT_W + 3] &&
      !pin_o[PORT_C * PORT_W + 3])
    else $error("led sink not pulling low");

  reset_in_a: assert property (
    rst_role && !pin_i[RPIN] && !rst_drive_req ##1 rst_role |-> ext_reset_req)
    else $error("reset pin low not requested");

  rst_gpio_in_a: assert property (
    !SMALL_PKG && !rst_role |-> !in_val[RST_PIN_LARGE])
    else $error("output-only pin shows input");

  level_map_a: assert property (
    cpu_wr && cpu_addr == LED_LVLH_ADDR |=> led_level[5][1] == $past(cpu_wdata[5]))
    else $error("led level pair wrong");

  led_write_c: cover property (cpu_wr && cpu_addr == LED_EN_ADDR ##1 led_sink_on != '0);
  alt_enable_c: cover property (ctl_wr_any && idx_reg[port_sel] == IDX_AF ##1 pcfg[1].af);
  rst_leave_c: cover property (rst_role ##1 !rst_role);
  od_alt_c: cover property (pcfg[1].af && pcfg[1].oc && alt_oe[1][pcfg[1].sel]);

endmodule : port_pin_ctl

// file: hdl/port_ctl_pkg.sv
// shared constants and carrier types for the port pin control block
// assumes a single 20 MHz system clock and byte-wide register strobes
package port_ctl_pkg;

  // ==========================================================
  // geometry
  localparam int NUM_PORTS = 4;
  localparam int PORT_W = 8;
  localparam int NPINS = NUM_PORTS * PORT_W;
  localparam int NALT = 4;

  // ==========================================================
  // register addresses
  localparam logic [11:0] PORT_BASE_ADDR = 12'hFD0;
  localparam logic [11:0] LED_EN_ADDR = 12'hF82;
  localparam logic [11:0] LED_LVLH_ADDR = 12'hF83;
  localparam logic [11:0] LED_LVLL_ADDR = 12'hF84;
  localparam logic [1:0] OFS_INDEX = 2'h0;
  localparam logic [1:0] OFS_CTRL = 2'h1;
  localparam logic [1:0] OFS_INPUT = 2'h2;
  localparam logic [1:0] OFS_OUTPUT = 2'h3;

  // ==========================================================
  // subregister indices behind the control register
  localparam logic [7:0] IDX_DIR = 8'h01;
  localparam logic [7:0] IDX_AF = 8'h02;
  localparam logic [7:0] IDX_OC = 8'h03;
  localparam logic [7:0] IDX_SEL1 = 8'h07;
  localparam logic [7:0] IDX_SEL2 = 8'h08;

  // ==========================================================
  // reset values
  localparam logic [7:0] AF_RST_ABC = 8'h00;
  localparam logic [7:0] AF_RST_D = 8'h01;
  localparam logic [7:0] AF_RST_A_SMALL = 8'h04;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] OC_RST = 8'h00;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] LED_RST = 8'h00;
  localparam logic [7:0] IDX_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ==========================================================
  // pin map
  localparam int PORT_A = 0;
  localparam int PORT_C = 2;
  localparam int PORT_D = 3;
  localparam int RST_PIN_SMALL = 2;
  localparam int RST_PIN_LARGE = 24;
  localparam logic [1:0] RST_ROLE_SEL = 2'h0;
  localparam logic [31:0] PRESENT_SMALL = 32'h0000_003F;
  localparam logic [31:0] PRESENT_LARGE = 32'h01FF_FFFF;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic dir;
    logic af;
    logic [1:0] sel;
    logic oc;
    logic out;
  } pin_cfg_t;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] af;
    logic [7:0] sel1;
    logic [7:0] sel2;
    logic [7:0] oc;
    logic [7:0] out;
  } port_cfg_t;

endpackage : port_ctl_pkg

// file: hdl/port_subreg_bank.sv
// one port's subregister bank reached through its index register
// assumes the top decodes the control and output-data strobes
`timescale 1ns/10ps
module port_subreg_bank import port_ctl_pkg::*; #(
  parameter logic [7:0] AF_RST = AF_RST_ABC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register access
  input wire logic ctl_wr,
  input wire logic out_wr,
  input wire logic [7:0] idx,
  input wire logic [7:0] wdata,
  output logic [7:0] rd_data,
  // configuration
  output port_cfg_t cfg
);

  // ==========================================================
  // subregisters
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.dir <= DIR_RST;
      cfg.af <= AF_RST;
      cfg.sel1 <= SEL_RST;
      cfg.sel2 <= SEL_RST;
      cfg.oc <= OC_RST;
      cfg.out <= OUT_RST;
    end else begin
      if (ctl_wr) begin
        unique case (idx)
          IDX_DIR: cfg.dir <= wdata;
          IDX_AF: cfg.af <= wdata;
          IDX_OC: cfg.oc <= wdata;
          IDX_SEL1: cfg.sel1 <= wdata;
          IDX_SEL2: cfg.sel2 <= wdata;
          default: ;
        endcase
      end
      if (out_wr) begin
        cfg.out <= wdata;
      end
    end
  end

  // ==========================================================
  // read-back; unmapped indices read zero
  always_comb begin
    unique case (idx)
      IDX_DIR: rd_data = cfg.dir;
      IDX_AF: rd_data = cfg.af;
      IDX_OC: rd_data = cfg.oc;
      IDX_SEL1: rd_data = cfg.sel1;
      IDX_SEL2: rd_data = cfg.sel2;
      default: rd_data = 8'h00;
    endcase
  end

endmodule : port_subreg_bank

// file: hdl/pin_drive_cell.sv
// one pin's driver: gpio, alternate function, led sink or reset role
// assumes pin_i is already synchronous to sys_clk
`timescale 1ns/10ps
module pin_drive_cell import port_ctl_pkg::*; (
  // configuration
  input pin_cfg_t cfg,
  input wire logic present,
  input wire logic out_only,
  input wire logic led_on,
  input wire logic rst_role,
  input wire logic rst_drive,
  // alternate functions
  input wire logic [NALT-1:0] alt_o,
  input wire logic [NALT-1:0] alt_oe,
  // pin
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic in_val
);

  logic drv;
  logic val;
  logic od;

  always_comb begin
    drv = 1'b0;
    val = 1'b0;
    if (rst_role) begin
      drv = rst_drive;
      val = 1'b0;
    end else if (led_on) begin
      drv = 1'b1;
      val = 1'b0;
    end else if (cfg.af) begin
      drv = alt_oe[cfg.sel];
      val = alt_o[cfg.sel];
    end else begin
      drv = !cfg.dir || out_only;
      val = cfg.out;
    end
  end

  // open drain sits after the mux so alternate functions obey it too
  assign od = cfg.oc || out_only || rst_role;
  assign pin_oe = present && drv && !(od && val);
  assign pin_o = od ? 1'b0 : val;
  // the output-only reset pin has no input path
  assign in_val = (present && !out_only) ? pin_i : 1'b0;

endmodule : pin_drive_cell

// file: testbench/pin_board.sv
// board-side model of the port pins: pull-ups and external pull-down switches
// assumes the design resolves its own o/oe per pin and the bench drives ext_low
`timescale 1ns/10ps
module pin_board import port_ctl_pkg::*; (
  // design side
  input wire logic [NPINS-1:0] pin_o,
  input wire logic [NPINS-1:0] pin_oe,
  // board controls
  input wire logic [NPINS-1:0] ext_low,
  input wire logic arst_n,
  // resolved levels
  output logic [NPINS-1:0] pin_i
);
  // ==========================================================
  // wire resolution
  // every line has a board pull-up, so a released line reads 1 unless its ext_low switch pulls it low while arst_n is high
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (pin_oe[i]) begin
        pin_i[i] = pin_o[i];
      end else if (ext_low[i] && arst_n) begin
        pin_i[i] = 1'b0;
      end else begin
        pin_i[i] = 1'b1;
      end
    end
  end
endmodule : pin_board

// file: testbench/port_pin_ctl_tb.sv
// self-checking bench for the port pin control top, large and small pin maps
// assumes pin_board resolves the pins; expectations come from bench functions
`timescale 1ns/10ps
module port_pin_ctl_tb import port_ctl_pkg::*; ;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] cpu_addr = 12'h000;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata;
  logic [NPINS-1:0] pin_i, pin_o, pin_oe, periph_in;
  logic [NPINS-1:0] ext_low = '0;
  logic [NPINS-1:0][NALT-1:0] alt_o = '0;
  logic [NPINS-1:0][NALT-1:0] alt_oe = '0;
  logic rst_drive_req = 1'b0;
  logic ext_reset_req;
  logic [PORT_W-1:0] led_sink_on;
  logic [PORT_W-1:0][1:0] led_level;
  logic [7:0] cpu_rdata_s;
  logic [NPINS-1:0] pin_i_s, pin_o_s, pin_oe_s, periph_in_s;
  logic ext_reset_req_s;
  logic [PORT_W-1:0] led_sink_on_s;
  int fails = 0;
  int total_checks = 0;

  always #25 sys_clk = ~sys_clk;

  port_pin_ctl dut (.sys_clk(sys_clk), .arst_n(arst_n), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .alt_o(alt_o), .alt_oe(alt_oe),
    .periph_in(periph_in), .rst_drive_req(rst_drive_req), .ext_reset_req(ext_reset_req),
    .led_sink_on(led_sink_on), .led_level(led_level));
  pin_board board (.pin_o(pin_o), .pin_oe(pin_oe), .ext_low(ext_low), .arst_n(arst_n),
    .pin_i(pin_i));

  // small map copy on the same bus; its reset role sits on port A bit two
  port_pin_ctl #(.SMALL_PKG(1'b1)) dut_small (.sys_clk(sys_clk), .arst_n(arst_n),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata_s), .pin_i(pin_i_s), .pin_o(pin_o_s), .pin_oe(pin_oe_s),
    .alt_o(alt_o), .alt_oe(alt_oe), .periph_in(periph_in_s), .rst_drive_req(rst_drive_req),
    .ext_reset_req(ext_reset_req_s), .led_sink_on(led_sink_on_s), .led_level());
  pin_board board_small (.pin_o(pin_o_s), .pin_oe(pin_oe_s), .ext_low(ext_low),
    .arst_n(arst_n), .pin_i(pin_i_s));

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge sys_clk);
    cpu_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge sys_clk);
    cpu_rd <= 1'b0;
    @(posedge sys_clk);
    d = cpu_rdata;
  endtask : rd

  function automatic logic [11:0] reg_at(input int p, input logic [1:0] ofs);
    return PORT_BASE_ADDR + 12'(p * 4) + {10'h000, ofs};
  endfunction : reg_at

  task automatic sub_wr(input int p, input logic [7:0] idx, d);
    wr(reg_at(p, OFS_INDEX), idx);
    wr(reg_at(p, OFS_CTRL), d);
  endtask : sub_wr

  task automatic sub_rd(input int p, input logic [7:0] idx, output logic [7:0] d);
    wr(reg_at(p, OFS_INDEX), idx);
    rd(reg_at(p, OFS_CTRL), d);
  endtask : sub_rd

  // {o, oe}; open drain only pulls low, a 1 releases the line
  function automatic logic [1:0] pin_exp(input logic v, e, od);
    return od ? {1'b0, e & ~v} : {v & e, e};
  endfunction : pin_exp

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check(32'({pin_o[RST_PIN_LARGE], pin_oe[RST_PIN_LARGE]}), 32'h1, "rst out");
    check(32'({pin_o_s[RST_PIN_SMALL], pin_oe_s[RST_PIN_SMALL]}), 32'h1, "small rst out");
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask : do_reset

  task automatic reset_values();
    logic [7:0] d;
    for (int p = 0; p < NUM_PORTS; p++) begin
      sub_rd(p, IDX_AF, d);
      check(32'(d), (p == 3) ? 32'h01 : 32'h00, "af reset");
      check(32'(cpu_rdata_s), (p == 0) ? 32'h04 : ((p == 3) ? 32'h01 : 32'h00),
        "small af reset");
      sub_rd(p, IDX_OC, d);
      check(32'(d), 32'h00, "oc reset");
    end
    check(32'(led_sink_on), 32'h00, "led reset");
  endtask : reset_values

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] d, dir, out, oc, af, s1, s2, h, l, lvl;
    logic [1:0] pe;
    int k;
    void'($urandom(32'h8F282B63));
    do_reset();
    reset_values();
    $display("test reset values done");

    check(32'(ext_reset_req), 32'h0, "rst idle");
    check(32'(pin_oe[RST_PIN_LARGE]), 32'h0, "rst released");
    ext_low[RST_PIN_LARGE] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(32'(ext_reset_req), 32'h1, "rst in");
    ext_low[RST_PIN_LARGE] <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(32'(ext_reset_req), 32'h0, "rst in gone");
    rst_drive_req <= 1'b1;
    @(posedge sys_clk);
    check(32'({pin_o[RST_PIN_LARGE], pin_oe[RST_PIN_LARGE]}), 32'h1, "rst drive");
    rst_drive_req <= 1'b0;
    sub_wr(3, IDX_DIR, 8'h00);
    sub_wr(3, IDX_AF, 8'h00);
    wr(reg_at(3, OFS_OUTPUT), 8'hFF);
    @(posedge sys_clk);
    check(32'(pin_oe[RST_PIN_LARGE]), 32'h0, "d0 high released");
    check(32'(periph_in[RST_PIN_LARGE]), 32'h0, "d0 no input");
    check(32'(pin_oe[NPINS-1:RST_PIN_LARGE+1]), 32'h0, "absent pins");
    wr(reg_at(3, OFS_OUTPUT), 8'h00);
    @(posedge sys_clk);
    check(32'({pin_o[RST_PIN_LARGE], pin_oe[RST_PIN_LARGE]}), 32'h1, "d0 low");
    $display("test shared reset pin done");

    // small map: reset role on port A bit two, full gpio once released
    ext_low[RST_PIN_SMALL] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(32'(ext_reset_req_s), 32'h1, "small rst in");
    sub_wr(0, IDX_AF, 8'h00);
    repeat (2) @(posedge sys_clk);
    check(32'({periph_in_s[RST_PIN_SMALL], ext_reset_req_s}), 32'h0, "small gpio in");
    ext_low[RST_PIN_SMALL] <= 1'b0;
    sub_wr(0, IDX_DIR, 8'hFB);
    wr(reg_at(0, OFS_OUTPUT), 8'h04);
    @(posedge sys_clk);
    check(32'({pin_o_s[RST_PIN_SMALL], pin_oe_s[RST_PIN_SMALL], periph_in_s[RST_PIN_SMALL]}),
      32'h7, "small gpio out");
    $display("test small reset pin done");

    for (int n = 0; n < 24; n++) begin
      {dir, out, oc, af} = $urandom;
      {s1, s2} = 16'($urandom);
      if (n == 0) begin
        af = 8'hFF;
        oc = 8'hFF;
      end
      if (n == 1) begin
        af = 8'h00;
        dir = 8'h00;
      end
      alt_o <= {$urandom, $urandom, $urandom, $urandom};
      alt_oe <= {$urandom, $urandom, $urandom, $urandom};
      sub_wr(n % 3, IDX_SEL1, s1);
      sub_wr(n % 3, IDX_SEL2, s2);
      sub_wr(n % 3, IDX_DIR, dir);
      sub_wr(n % 3, IDX_OC, oc);
      wr(reg_at(n % 3, OFS_OUTPUT), out);
      sub_wr(n % 3, IDX_AF, af);
      @(posedge sys_clk);
      for (int i = 0; i < PORT_W; i++) begin
        k = (n % 3) * PORT_W + i;
        if (af[i]) begin
          pe = pin_exp(alt_o[k][{s2[i], s1[i]}], alt_oe[k][{s2[i], s1[i]}], oc[i]);
        end else begin
          pe = pin_exp(out[i], ~dir[i], oc[i]);
        end
        check(32'({pin_o[k] & pin_oe[k], pin_oe[k]}), 32'(pe), "pin");
        // a released line floats to its board pull-up
        lvl[i] = pe[0] ? pe[1] : 1'b1;
        check(32'(periph_in[k]), 32'(lvl[i]), "periph in");
      end
      rd(reg_at(n % 3, OFS_INPUT), d);
      check(32'(d), 32'(lvl), "input reg");
      sub_rd(n % 3, IDX_AF, d);
      check(32'(d), 32'(af), "af readback");
      sub_rd(n % 3, IDX_OC, d);
      check(32'(d), 32'(oc), "oc readback");
    end
    $display("test pin drive done");

    for (int n = 0; n < 4; n++) begin
      {out, h, l} = 24'($urandom);
      if (n == 0) begin
        {out, h, l} = 24'hFFCCAA;
      end
      wr(LED_EN_ADDR, out);
      wr(LED_LVLH_ADDR, h);
      wr(LED_LVLL_ADDR, l);
      @(posedge sys_clk);
      check(32'(led_sink_on), 32'(out), "led enable");
      check(32'(led_sink_on_s), 32'h00, "small no led");
      for (int i = 0; i < PORT_W; i++) begin
        check(32'(led_level[i]), 32'({h[i], l[i]}), "led level");
      end
      rd(LED_EN_ADDR, d);
      check(32'(d), 32'(out), "led readback");
      rd(12'h000, d);
      check(32'(d), 32'h00, "unmapped");
      sub_rd(0, 8'h55, d);
      check(32'(d), 32'h00, "unknown index");
    end
    $display("test led sink done");

    do_reset();
    reset_values();
    $display("test second reset done");
    close_out();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    close_out();
  end
endmodule : port_pin_ctl_tb
